// *** logic/rgbp_defines.vh ***
// Constants for the three-channel LED PWM block
`ifndef RGBP_DEFINES_VH
`define RGBP_DEFINES_VH

// ----------------------------------------
// Clocks and timing
// ----------------------------------------
`define RGBP_CLK_HZ 200000000
`define RGBP_OSC_HZ 16000000
`define RGBP_TICK_DIV ((`RGBP_CLK_HZ + `RGBP_OSC_HZ / 2) / `RGBP_OSC_HZ)
`define RGBP_TICK_W 4
`define RGBP_RAMP_NS 1000
`define RGBP_CLK_MHZ 200
`define RGBP_RAMP_CYC ((`RGBP_RAMP_NS * `RGBP_CLK_MHZ) / 1000)
`define RGBP_RAMP_W 8

// ----------------------------------------
// PWM geometry
// ----------------------------------------
`define RGBP_DUTY_W 12
`define RGBP_CNT_W 17
`define RGBP_BASE_LOG2 15
`define RGBP_QTR_LOG2 13
`define RGBP_SLOT_LOG2 3
`define RGBP_SHIFT_488 2'h0
`define RGBP_SHIFT_244 2'h1
`define RGBP_SHIFT_122 2'h2
`define RGBP_THR_488 8'h08
`define RGBP_THR_244 8'h04

// ----------------------------------------
// Phase offsets in quarter periods
// ----------------------------------------
`define RGBP_OFS_NONE 2'h0
`define RGBP_OFS_QTR 2'h1
`define RGBP_OFS_3QTR 2'h3

`endif

// *** logic/rgbp_pwm.v ***
// Three-channel LED PWM with phase shift and current source power save
// How it works
// R1: New duty takes effect only when the running period ends.
// R2: Phase shift enable is captured by the initialisation strobe.
// R3: Phase shift off: all channels follow red's timing, no offsets.
// R4: Phase shift on: offsets hold even with differing channel frequencies.
// R5: Slower channels stay aligned, skipping whole periods of the fast grid.
// R6: Leaving power save restarts all channels with correct offsets.
// R7: Green offset zero, red quarter period, blue three quarters.
// R8: An all-zero colour command enters power save.
// R9: Any non-zero colour command leaves power save, nothing more needed.
// R10: Green restarts about 1 us after power save ends; the code restarts it as power save ends, 1 us after the sources switch on.
// R11: Reset leaves colour zero, LEDs off, in power save.
// R12: Offsets come from each channel's counter start within its own period.
// R13: Each channel has a 12-bit duty.
// R14: Base period is 2^15 oscillator ticks, doubled or quadrupled.
// R15: Frequency per channel from its colour value and intensity scale.
`timescale 1ns/1ps
`default_nettype none
`include "rgbp_defines.vh"

// ----------------------------------------
// One PWM channel
// ----------------------------------------
module rgbp_channel
(
    input wire clk_sys,
    input wire rst,
    input wire tick,
    input wire run,
    input wire restart,
    input wire [`RGBP_CNT_W-1:0] master,
    input wire [1:0] offsetSel,
    input wire [`RGBP_DUTY_W-1:0] nextDuty,
    input wire [1:0] nextShift,
    output reg pwmOut
);
    reg [`RGBP_DUTY_W-1:0] activeDuty;
    reg [1:0] activeShift;
    reg started;
    wire [`RGBP_CNT_W-1:0] masterNext;
    wire [`RGBP_CNT_W-1:0] curCnt;
    wire [`RGBP_CNT_W-1:0] curNext;
    wire [`RGBP_CNT_W-1:0] newNext;
    reg [`RGBP_CNT_W-1:0] slotWide;
    reg [`RGBP_DUTY_W-1:0] slot;

    // Counter derived from the shared master so phase survives any period mix
    function [`RGBP_CNT_W-1:0] chanCount;
        input [`RGBP_CNT_W-1:0] m;
        input [1:0] ofs;
        input [1:0] sh;
        reg [`RGBP_CNT_W-1:0] off;
        reg [`RGBP_CNT_W-1:0] mask;
        begin
            off = {{(`RGBP_CNT_W-2){1'b0}}, ofs} << (`RGBP_QTR_LOG2 + sh); // R7 R12
            mask = ({{(`RGBP_CNT_W-1){1'b0}}, 1'b1} << (`RGBP_BASE_LOG2 + sh)) - 1'b1; // R14
            // Subtracting puts this channel's boundary the offset after green's
            chanCount = (m - off) & mask; // R4 R5
        end
    endfunction

    assign masterNext = master + 1'b1;
    assign curCnt = chanCount(master, offsetSel, activeShift);
    assign curNext = chanCount(masterNext, offsetSel, activeShift);
    assign newNext = chanCount(masterNext, offsetSel, nextShift);

    always @*
    begin
        slotWide = curCnt >> (`RGBP_SLOT_LOG2 + activeShift);
        slot = slotWide[`RGBP_DUTY_W-1:0];
    end

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            activeDuty <= {`RGBP_DUTY_W{1'b0}};
            activeShift <= `RGBP_SHIFT_488;
            started <= 1'b0;
            pwmOut <= 1'b0;
        end
        else
        begin
            if (restart)
            begin
                // Delayed channels stay dark until their counter first wraps
                started <= offsetSel == `RGBP_OFS_NONE; // R6
                activeDuty <= nextDuty;
                activeShift <= nextShift;
            end
            else if (run && tick && curNext == {`RGBP_CNT_W{1'b0}})
            begin
                // Swap on the tick that wraps the count, so no slot mixes duties
                activeDuty <= nextDuty; // R1
                activeShift <= nextShift; // R15
                // Off the new grid's boundary the channel sits out whole periods
                started <= newNext == {`RGBP_CNT_W{1'b0}}; // R5
            end
            pwmOut <= run && started && (slot < activeDuty); // R13
        end
    end
endmodule // rgbp_channel

// ----------------------------------------
// Top: command capture, power save, timing
// ----------------------------------------
module rgbp_pwm
(
    input wire clk_sys,
    input wire rst,
    input wire initStrobe,
    input wire phaseShiftEnable,
    input wire [1:0] intensityScale,
    input wire setColour,
    input wire [7:0] colourRed,
    input wire [7:0] colourGreen,
    input wire [7:0] colourBlue,
    input wire [`RGBP_DUTY_W-1:0] dutyRed,
    input wire [`RGBP_DUTY_W-1:0] dutyGreen,
    input wire [`RGBP_DUTY_W-1:0] dutyBlue,
    output wire pwmRed,
    output wire pwmGreen,
    output wire pwmBlue,
    output reg powerSave,
    output reg currentSourceOn
);
    localparam ST_SAVE = 2'h0;
    localparam ST_RAMP = 2'h1;
    localparam ST_RUN = 2'h2;

    reg [1:0] state;
    reg [`RGBP_RAMP_W-1:0] rampCnt;
    reg [`RGBP_TICK_W-1:0] tickCnt;
    reg [`RGBP_CNT_W-1:0] master;
    reg phaseOn;
    reg [`RGBP_DUTY_W-1:0] pendRed;
    reg [`RGBP_DUTY_W-1:0] pendGreen;
    reg [`RGBP_DUTY_W-1:0] pendBlue;
    reg [1:0] shiftRed;
    reg [1:0] shiftGreen;
    reg [1:0] shiftBlue;
    wire tick;
    wire run;
    wire restart;
    wire colourZero;

    function [1:0] pickShift;
        input [7:0] colour;
        input [1:0] scale;
        begin
            if (colour >= (`RGBP_THR_488 << scale))
                pickShift = `RGBP_SHIFT_488; // R15
            else if (colour >= (`RGBP_THR_244 << scale))
                pickShift = `RGBP_SHIFT_244;
            else
                pickShift = `RGBP_SHIFT_122;
        end
    endfunction

    assign colourZero = {colourRed, colourGreen, colourBlue} == 24'h000000;
    assign tick = tickCnt == (`RGBP_TICK_DIV - 1);
    assign run = state == ST_RUN;
    assign restart = state == ST_RAMP && rampCnt == (`RGBP_RAMP_CYC - 1); // R10

    // ----------------------------------------
    // Commands and power save sequencing
    // ----------------------------------------
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state <= ST_SAVE; // R11
            powerSave <= 1'b1;
            currentSourceOn <= 1'b0;
            rampCnt <= {`RGBP_RAMP_W{1'b0}};
            phaseOn <= 1'b0;
            pendRed <= {`RGBP_DUTY_W{1'b0}};
            pendGreen <= {`RGBP_DUTY_W{1'b0}};
            pendBlue <= {`RGBP_DUTY_W{1'b0}};
            shiftRed <= `RGBP_SHIFT_122;
            shiftGreen <= `RGBP_SHIFT_122;
            shiftBlue <= `RGBP_SHIFT_122;
        end
        else
        begin
            if (initStrobe)
                phaseOn <= phaseShiftEnable; // R2
            if (setColour)
            begin
                pendRed <= dutyRed;
                pendGreen <= dutyGreen;
                pendBlue <= dutyBlue;
                shiftRed <= pickShift(colourRed, intensityScale);
                shiftGreen <= pickShift(colourGreen, intensityScale);
                shiftBlue <= pickShift(colourBlue, intensityScale);
            end
            case (state)
                ST_SAVE:
                begin
                    if (setColour && !colourZero)
                    begin
                        state <= ST_RAMP; // R9
                        currentSourceOn <= 1'b1;
                        rampCnt <= {`RGBP_RAMP_W{1'b0}};
                    end
                end
                ST_RAMP:
                begin
                    // Analog ramp-up before any channel may light
                    if (setColour && colourZero)
                    begin
                        state <= ST_SAVE; // R8
                        currentSourceOn <= 1'b0;
                    end
                    else if (restart)
                    begin
                        state <= ST_RUN;
                        powerSave <= 1'b0;
                    end
                    else
                        rampCnt <= rampCnt + 1'b1;
                end
                default:
                begin
                    if (setColour && colourZero)
                    begin
                        state <= ST_SAVE; // R8
                        powerSave <= 1'b1;
                        currentSourceOn <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // Oscillator tick and shared phase counter
    // ----------------------------------------
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            tickCnt <= {`RGBP_TICK_W{1'b0}};
            master <= {`RGBP_CNT_W{1'b0}};
        end
        else
        begin
            if (restart || tick)
                tickCnt <= {`RGBP_TICK_W{1'b0}};
            else
                tickCnt <= tickCnt + 1'b1;
            if (restart)
                master <= {`RGBP_CNT_W{1'b0}}; // R6
            else if (run && tick)
                master <= master + 1'b1;
        end
    end

    // ----------------------------------------
    // Channels
    // ----------------------------------------
    rgbp_channel u_green
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tick),
        .run(run),
        .restart(restart),
        .master(master),
        .offsetSel(`RGBP_OFS_NONE), // R7
        .nextDuty(pendGreen),
        .nextShift(phaseOn ? shiftGreen : shiftRed), // R3
        .pwmOut(pwmGreen)
    );

    rgbp_channel u_red
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tick),
        .run(run),
        .restart(restart),
        .master(master),
        .offsetSel(phaseOn ? `RGBP_OFS_QTR : `RGBP_OFS_NONE), // R7
        .nextDuty(pendRed),
        .nextShift(shiftRed),
        .pwmOut(pwmRed)
    );

    rgbp_channel u_blue
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tick),
        .run(run),
        .restart(restart),
        .master(master),
        .offsetSel(phaseOn ? `RGBP_OFS_3QTR : `RGBP_OFS_NONE), // R7
        .nextDuty(pendBlue),
        .nextShift(phaseOn ? shiftBlue : shiftRed), // R3
        .pwmOut(pwmBlue)
    );
endmodule // rgbp_pwm
`default_nettype wire

// *** tb/rgbp_pwm_sva.sv ***
// Port assertions for the three-channel LED PWM
`timescale 1ns/1ps
`default_nettype none
module rgbp_pwm_sva
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic initStrobe,
    input wire logic phaseShiftEnable,
    input wire logic setColour,
    input wire logic [7:0] colourRed,
    input wire logic [7:0] colourGreen,
    input wire logic [7:0] colourBlue,
    input wire logic pwmRed,
    input wire logic pwmGreen,
    input wire logic pwmBlue,
    input wire logic powerSave,
    input wire logic currentSourceOn
);
default clocking cb @(posedge clk_sys); endclocking
default disable iff (rst);
// Slightly under a quarter of the fastest period, to allow for tick phase
localparam int QTR = 106000;
logic phaseOn;
logic [16:0] runCnt;
wire zeroCmd = setColour && ({colourRed, colourGreen, colourBlue} == 24'h000000);
always_ff @(posedge clk_sys or posedge rst)
begin
    if (rst)
    begin
        phaseOn <= 1'b0;
        runCnt <= 17'h00000;
    end
    else
    begin
        if (initStrobe)
            phaseOn <= phaseShiftEnable;
        if (powerSave)
            runCnt <= 17'h00000;
        else if (runCnt != 17'h1FFFF)
            runCnt <= runCnt + 17'h00001;
    end
end
a_save_on_zero: assert property (zeroCmd |=> powerSave && !currentSourceOn)
    else $error("zero colour did not enter power save");
a_wake_source: assert property (setColour && !zeroCmd |=> currentSourceOn)
    else $error("non-zero colour left current sources off");
a_save_dark: assert property (powerSave [*2] |-> !(pwmRed || pwmGreen || pwmBlue))
    else $error("output high in power save");
a_ramp_length: assert property ($rose(currentSourceOn) |-> ##190 powerSave ##[1:15] !powerSave)
    else $error("ramp after wake has wrong length");
a_run_powered: assert property (!powerSave |-> currentSourceOn)
    else $error("running without current sources");
a_wake_delay: assert property ($fell(powerSave) |-> $past(currentSourceOn, 150))
    else $error("channels restarted without ramp");
a_red_offset: assert property (phaseOn && runCnt < QTR |-> !pwmRed)
    else $error("red started before its quarter offset");
// Blue's three-quarter offset outlasts the saturating run counter
a_blue_offset: assert property (phaseOn && runCnt != 17'h1FFFF |-> !pwmBlue)
    else $error("blue started before its offset");
c_wake: cover property ($fell(powerSave));
c_phase_run: cover property (phaseOn && $rose(pwmGreen));
c_sleep_from_run: cover property (zeroCmd && !powerSave);
endmodule // rgbp_pwm_sva
bind rgbp_pwm rgbp_pwm_sva rgbp_pwm_sva_i (.clk_sys(clk_sys), .rst(rst),
    .initStrobe(initStrobe), .phaseShiftEnable(phaseShiftEnable), .setColour(setColour),
    .colourRed(colourRed), .colourGreen(colourGreen), .colourBlue(colourBlue),
    .pwmRed(pwmRed), .pwmGreen(pwmGreen), .pwmBlue(pwmBlue), .powerSave(powerSave),
    .currentSourceOn(currentSourceOn));
`default_nettype wire

// *** tb/rgbp_host.sv ***
// Host model issuing colour and initialisation commands
`timescale 1ns/1ps
`default_nettype none
module rgbp_host
(
    input wire logic clk_sys,
    output logic initStrobe,
    output logic phaseShiftEnable,
    output logic [1:0] intensityScale,
    output logic setColour,
    output logic [23:0] colour,
    output logic [35:0] duty
);
initial
begin
    initStrobe = 1'b0;
    phaseShiftEnable = 1'b1;
    intensityScale = 2'h3;
    setColour = 1'b0;
    colour = 24'h5A5A5A;
    duty = 36'hA5A5A5A5A;
end
task automatic init(input logic ph);
    @(posedge clk_sys);
    #1;
    phaseShiftEnable = ph;
    initStrobe = 1'b1;
    @(posedge clk_sys);
    #1;
    initStrobe = 1'b0;
    phaseShiftEnable = ~ph;
endtask
// Idle data lines carry the inverse so stale values are never trusted
task automatic send(input logic [23:0] c, input logic [35:0] d, input logic [1:0] sc);
    @(posedge clk_sys);
    #1;
    colour = c;
    duty = d;
    intensityScale = sc;
    setColour = 1'b1;
    @(posedge clk_sys);
    #1;
    setColour = 1'b0;
    colour = ~c;
    duty = ~d;
    intensityScale = ~sc;
endtask
endmodule // rgbp_host
`default_nettype wire

// *** tb/rgb_pwm_phase_power_save_bench.sv ***
// Self-checking bench for the three-channel LED PWM
`timescale 1ns/1ps
`default_nettype none
module rgb_pwm_phase_power_save_bench;
logic clk_sys, rst, initStrobe, phaseShiftEnable, setColour;
logic [1:0] intensityScale;
logic [23:0] colour;
logic [35:0] duty;
wire pwmRed, pwmGreen, pwmBlue, powerSave, currentSourceOn;
int fails = 0;
int compares = 0;
logic [23:0] rc [7] = '{24'hFFFFFF, 24'h040404, 24'h030303, 24'h080808, 24'h0F0F0F,
    24'h404040, 24'hFF0303};
logic [1:0] rs [7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
int rt [7] = '{8, 16, 32, 16, 32, 8, 8};
rgbp_host rgbp_host_i (.clk_sys(clk_sys), .initStrobe(initStrobe),
    .phaseShiftEnable(phaseShiftEnable), .intensityScale(intensityScale),
    .setColour(setColour), .colour(colour), .duty(duty));
rgbp_pwm rgbp_pwm_i (.clk_sys(clk_sys), .rst(rst), .initStrobe(initStrobe),
    .phaseShiftEnable(phaseShiftEnable), .intensityScale(intensityScale),
    .setColour(setColour), .colourRed(colour[23:16]), .colourGreen(colour[15:8]),
    .colourBlue(colour[7:0]), .dutyRed(duty[35:24]), .dutyGreen(duty[23:12]),
    .dutyBlue(duty[11:0]), .pwmRed(pwmRed), .pwmGreen(pwmGreen), .pwmBlue(pwmBlue),
    .powerSave(powerSave), .currentSourceOn(currentSourceOn));
task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
        fails++;
        $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
endtask
task automatic wrap_up;
    if (fails == 0 && compares > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask
task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
endtask
// Wake from save and return in the cycle green first shows high
task automatic wake(input logic [23:0] c, input logic [35:0] d, input logic [1:0] sc);
    int n;
    n = 0;
    rgbp_host_i.send(c, d, sc);
    check("sources", currentSourceOn, 1);
    cyc(185);
    check("ramp", powerSave, 1);
    while (pwmGreen !== 1'b1 && n < 60)
    begin
        cyc(1);
        n++;
    end
    check("green start", n > 10 && n < 45, 1);
endtask
task automatic sleep;
    rgbp_host_i.send(24'h000000, 36'h000000000, 2'h0);
    check("save", {powerSave, currentSourceOn}, 2'b10);
    cyc(2);
    check("dark", {pwmRed, pwmGreen, pwmBlue}, 3'h0);
endtask
task automatic high_len(output int n);
    n = 0;
    while (pwmGreen === 1'b1 && n < 2000)
    begin
        cyc(1);
        n++;
    end
endtask
task automatic t_update;
    int n;
    wake(24'hFFFFFF, 36'h001001001, 2'h0);
    high_len(n);
    rgbp_host_i.send(24'hFFFFFF, 36'hFFFFFFFFF, 2'h0);
    n = 0;
    repeat (2000)
    begin
        cyc(1);
        n += (pwmGreen !== 1'b0);
    end
    check("held duty", n, 0);
    sleep();
endtask
task automatic t_rates;
    int n;
    for (int i = 0; i < 7; i++)
    begin
        wake(rc[i], 36'h001001001, rs[i]);
        check("red blue with green", {pwmRed, pwmBlue}, 2'b11);
        high_len(n);
        check("green high", n, rt[i] * 13);
        sleep();
    end
endtask
task automatic t_phase;
    int n;
    int len;
    n = 0;
    rgbp_host_i.init(1'b1);
    wake(24'hFF03FF, 36'h001001001, 2'h0);
    check("offset start", {pwmRed, pwmBlue}, 2'b00);
    high_len(len);
    check("green own rate", len, 416);
    repeat (3000)
    begin
        cyc(1);
        n += ((pwmRed | pwmBlue) !== 1'b0);
    end
    check("offset hold", n, 0);
    sleep();
    rgbp_host_i.init(1'b0);
endtask
initial
begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
end
initial
begin
    #200000;
    fails++;
    wrap_up();
end
initial
begin
    rst = 1'b1;
    cyc(20);
    rst = 1'b0;
    check("reset state", {powerSave, currentSourceOn, pwmRed, pwmGreen, pwmBlue}, 5'h10);
    t_update();
    t_rates();
    t_phase();
    wrap_up();
end
endmodule // rgb_pwm_phase_power_save_bench
`default_nettype wire
